//--- logic/adcm_pkg.sv
// constants, carriers and helpers for the converter configuration bank
`default_nettype none
package adcm_pkg;

  // register offsets
  localparam logic [7:0] ADCM_ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADCM_ADDR_GENERAL = 8'h01;
  localparam logic [7:0] ADCM_ADDR_AVG = 8'h03;
  localparam logic [7:0] ADCM_ADDR_OPMODE = 8'h04;
  localparam logic [7:0] ADCM_ADDR_PINFN = 8'h05;
  localparam logic [7:0] ADCM_ADDR_PINDIR = 8'h07;

  // reset values
  localparam logic [2:0] ADCM_RST_AVG = 3'h0;
  localparam logic [7:0] ADCM_RST_OPMODE = 8'h00;
  localparam logic [7:0] ADCM_RST_PINFN = 8'h00;
  localparam logic [7:0] ADCM_RST_PINDIR = 8'h00;
  localparam logic [7:0] ADCM_RD_UNMAPPED = 8'h00;

  // field codes
  localparam logic [1:0] ADCM_MODE_MANUAL = 2'h0;
  localparam logic [1:0] ADCM_MODE_AUTO = 2'h1;
  localparam logic ADCM_OSC_FAST = 1'b0;
  localparam logic ADCM_OSC_LOWPWR = 1'b1;
  localparam logic [7:0] ADCM_AVG_ONE = 8'h01;

  typedef struct packed {
    logic       cont_on_err;
    logic [1:0] trig_mode;
    logic       timing_source_select;
    logic [3:0] clk_div;
  } adcm_opmode_type;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } adcm_reg_req_type;

  typedef enum logic [0:0] {
    ADCM_SEQ_RUN   = 1'b0,
    ADCM_SEQ_PAUSE = 1'b1
  } adcm_seq_type;

  typedef struct packed {
    logic [2:0]      avg;
    adcm_opmode_type opm;
    logic [7:0]      pin_fn;
    logic [7:0]      pin_dir;
    adcm_seq_type    seq;
    logic [7:0]      eff_gpio;
    logic [7:0]      eff_out;
    logic [7:0]      avg_samples;
    logic [7:0]      rdata;
    logic            rvalid;
  } adcm_state_type;

  localparam adcm_state_type ADCM_STATE_RST = '{
    avg:         ADCM_RST_AVG,
    opm:         adcm_opmode_type'(ADCM_RST_OPMODE),
    pin_fn:      ADCM_RST_PINFN,
    pin_dir:     ADCM_RST_PINDIR,
    seq:         ADCM_SEQ_RUN,
    eff_gpio:    8'h00,
    eff_out:     8'h00,
    avg_samples: ADCM_AVG_ONE,
    rdata:       8'h00,
    rvalid:      1'b0
  };

  // code zero is a single sample, code n is two to the n
  function automatic logic [7:0] adcm_avg_samples(input logic [2:0] code);
    return ADCM_AVG_ONE << code;
  endfunction : adcm_avg_samples

  function automatic logic adcm_is_mapped(input logic [7:0] addr);
    return (addr == ADCM_ADDR_AVG) || (addr == ADCM_ADDR_OPMODE) ||
           (addr == ADCM_ADDR_PINFN) || (addr == ADCM_ADDR_PINDIR);
  endfunction : adcm_is_mapped

  // status and general control live elsewhere and stay writable
  function automatic logic adcm_is_exempt(input logic [7:0] addr);
    return (addr == ADCM_ADDR_STATUS) || (addr == ADCM_ADDR_GENERAL);
  endfunction : adcm_is_exempt

endpackage : adcm_pkg
`default_nettype wire

//--- logic/adcm_pin_resolve.sv
// per-channel effective pin function and direction
`timescale 1ns/1ps
`default_nettype none
module adcm_pin_resolve (
  input  wire logic [7:0] pin_fn_in,
  input  wire logic [7:0] pin_dir_in,
  input  wire logic       force_analog_all_in,
  input  wire logic       crc_force_in,
  output logic      [7:0] gpio_mask_out,
  output logic      [7:0] out_mask_out
);

  logic force_all;

  always_comb begin
    force_all = force_analog_all_in | crc_force_in;
    gpio_mask_out = force_all ? 8'h00 : pin_fn_in;
    out_mask_out = gpio_mask_out & pin_dir_in;
  end

endmodule : adcm_pin_resolve
`default_nettype wire

//--- logic/adcm_config_regs.sv
// configuration register bank: averaging, operating mode, pin function and direction
//
// Behaviour
// - three-bit code selects averaged sample count
// - averaging register upper five bits read zero
// - continuation clear: keep sequencing and pins
// - continuation set: force analog, pause, resume
// - bits 6-5 select host or autonomous trigger
// - bit 4 selects fast or low-power oscillator
// - divider bits 3-0 apply only in autonomous
// - pin-function bit: analog or gpio per channel
// - pin-direction bit: input or output per gpio
// - all four registers reset to zero
// - crc error blocks writes except 0x00, 0x01
// - channel reset forces every channel analog
`timescale 1ns/1ps
`default_nettype none
module adcm_config_regs (
  input  wire logic                     clk_in,
  input  wire logic                     sys_rst_in,
  input  wire adcm_pkg::adcm_reg_req_type reg_req_in,
  input  wire logic                     crc_err_flag_in,
  input  wire logic                     force_analog_all_in,
  output logic                          wr_ack_out,
  output logic                          wr_refused_out,
  output logic                    [7:0] rd_data_out,
  output logic                          rd_valid_out,
  output logic                    [2:0] averaging_ratio_out,
  output logic                    [7:0] avg_samples_out,
  output logic                    [1:0] conversion_trigger_mode_out,
  output logic                          timing_source_select_out,
  output logic                    [3:0] clk_div_out,
  output logic                          clk_div_active_out,
  output logic                          error_continuation_ctl_out,
  output logic                          seq_run_out,
  output logic                          seq_paused_out,
  output logic                    [7:0] pin_gpio_out,
  output logic                    [7:0] pin_output_out,
  output logic                    [7:0] analog_channel_input_out
);

  adcm_pkg::adcm_state_type st_q;
  adcm_pkg::adcm_state_type st_d;

  logic       mapped;
  logic       wr_ok;
  logic       crc_force;
  logic [7:0] gpio_mask;
  logic [7:0] out_mask;

  assign mapped = adcm_pkg::adcm_is_mapped(reg_req_in.addr);
  assign wr_ok = reg_req_in.wr_en & mapped & ~crc_err_flag_in;
  assign wr_ack_out = wr_ok;
  assign wr_refused_out = reg_req_in.wr_en & mapped & crc_err_flag_in;
  // force analog only with continuation set
  assign crc_force = crc_err_flag_in & st_q.opm.cont_on_err;

  adcm_pin_resolve u_resolve (
    .pin_fn_in           (st_d.pin_fn),
    .pin_dir_in          (st_d.pin_dir),
    .force_analog_all_in (force_analog_all_in),
    .crc_force_in        (crc_force),
    .gpio_mask_out       (gpio_mask),
    .out_mask_out        (out_mask)
  );

  always_comb begin
    st_d = st_q;
    st_d.rvalid = 1'b0;
    if (wr_ok) begin
      unique case (reg_req_in.addr)
        adcm_pkg::ADCM_ADDR_AVG: begin
          st_d.avg = reg_req_in.wdata[2:0];
        end
        adcm_pkg::ADCM_ADDR_OPMODE: begin
          st_d.opm = adcm_pkg::adcm_opmode_type'(reg_req_in.wdata);
        end
        adcm_pkg::ADCM_ADDR_PINFN: begin
          st_d.pin_fn = reg_req_in.wdata;
        end
        adcm_pkg::ADCM_ADDR_PINDIR: begin
          st_d.pin_dir = reg_req_in.wdata;
        end
        default: begin
          st_d.pin_dir = st_q.pin_dir;
        end
      endcase
    end
    if (reg_req_in.rd_en) begin
      st_d.rvalid = 1'b1;
      unique case (reg_req_in.addr)
        adcm_pkg::ADCM_ADDR_AVG: begin
          st_d.rdata = {5'h00, st_q.avg};
        end
        adcm_pkg::ADCM_ADDR_OPMODE: begin
          st_d.rdata = st_q.opm;
        end
        adcm_pkg::ADCM_ADDR_PINFN: begin
          st_d.rdata = st_q.pin_fn;
        end
        adcm_pkg::ADCM_ADDR_PINDIR: begin
          st_d.rdata = st_q.pin_dir;
        end
        default: begin
          st_d.rdata = adcm_pkg::ADCM_RD_UNMAPPED;
        end
      endcase
    end
    unique case (st_q.seq)
      adcm_pkg::ADCM_SEQ_RUN: begin
        if (crc_force) begin
          st_d.seq = adcm_pkg::ADCM_SEQ_PAUSE;
        end
      end
      adcm_pkg::ADCM_SEQ_PAUSE: begin
        if (!crc_force) begin
          st_d.seq = adcm_pkg::ADCM_SEQ_RUN;
        end
      end
    endcase
    // pin view registered so it lines up with the pause state
    st_d.eff_gpio = gpio_mask;
    st_d.eff_out = out_mask;
    st_d.avg_samples = adcm_pkg::adcm_avg_samples(st_d.avg);
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_q <= adcm_pkg::ADCM_STATE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign rd_data_out = st_q.rdata;
  assign rd_valid_out = st_q.rvalid;
  assign averaging_ratio_out = st_q.avg;
  assign avg_samples_out = st_q.avg_samples;
  assign conversion_trigger_mode_out = st_q.opm.trig_mode;
  assign timing_source_select_out = st_q.opm.timing_source_select;
  assign clk_div_out = st_q.opm.clk_div;
  assign clk_div_active_out = (st_q.opm.trig_mode == adcm_pkg::ADCM_MODE_AUTO);
  assign error_continuation_ctl_out = st_q.opm.cont_on_err;
  assign seq_run_out = (st_q.seq == adcm_pkg::ADCM_SEQ_RUN);
  assign seq_paused_out = (st_q.seq == adcm_pkg::ADCM_SEQ_PAUSE);
  assign pin_gpio_out = st_q.eff_gpio;
  assign pin_output_out = st_q.eff_out;
  assign analog_channel_input_out = ~st_q.eff_gpio;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  a_avg_rsvd_zero: assert property (
    reg_req_in.rd_en && reg_req_in.addr == adcm_pkg::ADCM_ADDR_AVG
    |=> rd_valid_out && rd_data_out[7:3] == 5'h00 && rd_data_out[2:0] == $past(st_q.avg))
    else $error("averaging readback wrong");

  a_avg_sample_map: assert property (
    ##1 (averaging_ratio_out == 3'h0) ? (avg_samples_out == 8'h01)
                                      : (avg_samples_out == (8'h01 << averaging_ratio_out)))
    else $error("sample count does not match code");

  a_write_blocked: assert property (
    reg_req_in.wr_en && crc_err_flag_in && mapped
    |=> st_q.pin_fn == $past(st_q.pin_fn) && st_q.pin_dir == $past(st_q.pin_dir) &&
        st_q.opm == $past(st_q.opm) && st_q.avg == $past(st_q.avg))
    else $error("write landed during crc error");

  a_pinfn_write: assert property (
    reg_req_in.wr_en && !crc_err_flag_in && reg_req_in.addr == adcm_pkg::ADCM_ADDR_PINFN
    |=> st_q.pin_fn == $past(reg_req_in.wdata))
    else $error("pin function write lost");

  a_mode_write: assert property (
    reg_req_in.wr_en && !crc_err_flag_in && reg_req_in.addr == adcm_pkg::ADCM_ADDR_OPMODE
    |=> conversion_trigger_mode_out == $past(reg_req_in.wdata[6:5]) &&
        timing_source_select_out == $past(reg_req_in.wdata[4]) &&
        clk_div_out == $past(reg_req_in.wdata[3:0]))
    else $error("operating mode write lost");

  a_div_active: assert property (
    reg_req_in.wr_en && !crc_err_flag_in && reg_req_in.addr == adcm_pkg::ADCM_ADDR_OPMODE &&
    reg_req_in.wdata[6:5] == 2'h1 |=> clk_div_active_out)
    else $error("divider not active in autonomous mode");

  a_force_analog: assert property (
    force_analog_all_in |=> pin_gpio_out == 8'h00 && pin_output_out == 8'h00)
    else $error("channel reset left a gpio");

  a_err_pause: assert property (
    crc_err_flag_in && st_q.opm.cont_on_err |=> seq_paused_out && pin_gpio_out == 8'h00)
    else $error("no pause on crc error");

  a_err_resume: assert property (
    seq_paused_out && !crc_err_flag_in && !force_analog_all_in
    |=> seq_run_out ##0 pin_gpio_out == st_q.pin_fn)
    else $error("no resume after error cleared");

  a_err_keep: assert property (
    crc_err_flag_in && !st_q.opm.cont_on_err && !force_analog_all_in && seq_run_out
    |=> seq_run_out && pin_gpio_out == $past(st_q.pin_fn))
    else $error("pins or sequencing disturbed");

  a_dir_gated: assert property (
    ##1 (pin_output_out & ~pin_gpio_out) == 8'h00)
    else $error("analog channel driven as output");

  a_dir_follow: assert property (
    !force_analog_all_in && !crc_force
    |=> pin_output_out == (st_q.pin_fn & st_q.pin_dir))
    else $error("direction not applied");

  a_reset_zero: assert property (
    $past(sys_rst_in) |-> st_q.avg == 3'h0 && st_q.opm == 8'h00 &&
                          st_q.pin_fn == 8'h00 && st_q.pin_dir == 8'h00)
    else $error("registers not zero after reset");

  c_pause: cover property (seq_run_out ##1 seq_paused_out ##[1:20] seq_run_out);
  c_refused: cover property (wr_refused_out);
  c_force: cover property (force_analog_all_in && st_q.pin_fn != 8'h00);
  c_output_pin: cover property (pin_output_out != 8'h00);

endmodule : adcm_config_regs
`default_nettype wire

//--- tb/adcm_host_model.sv
// host model driving the register request port
`timescale 1ns/1ps
`default_nettype none
module adcm_host_model (
  input  wire logic                       clk_in,
  output var  adcm_pkg::adcm_reg_req_type req_out,
  input  wire logic                       ack_in,
  input  wire logic                       refused_in,
  input  wire logic                 [7:0] rd_data_in,
  input  wire logic                       rd_valid_in
);
  initial req_out = '0;

  // held from a falling edge through the taking edge; resp is {ack, refused}
  task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] resp);
    @(negedge clk_in);
    req_out = '{1'b1, 1'b0, a, v};
    @(posedge clk_in);
    resp = {ack_in, refused_in};
    @(negedge clk_in);
    req_out = '0;
  endtask : wr

  // data is only trusted with its valid pulse
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk_in);
    req_out = '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_in);
    @(negedge clk_in);
    req_out = '0;
    v = (rd_valid_in === 1'b1) ? rd_data_in : 8'hEE;
  endtask : rd
endmodule : adcm_host_model
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                       clk_in, sys_rst_in, crc_err, force_an;
  adcm_pkg::adcm_reg_req_type req;
  logic                       ack, refused, rvalid, cdiv_act, cont, run, paused, osc;
  logic [7:0]                 rdata, samples, gpio, outm, analog, d;
  logic [2:0]                 avg;
  logic [1:0]                 mode, resp;
  logic [3:0]                 cdiv;
  int                         fail_count = 0;
  int                         n_compared = 0;
  int                         cycles = 0;

  adcm_config_regs dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_req_in(req),
    .crc_err_flag_in(crc_err), .force_analog_all_in(force_an), .wr_ack_out(ack),
    .wr_refused_out(refused), .rd_data_out(rdata), .rd_valid_out(rvalid),
    .averaging_ratio_out(avg), .avg_samples_out(samples),
    .conversion_trigger_mode_out(mode), .timing_source_select_out(osc),
    .clk_div_out(cdiv), .clk_div_active_out(cdiv_act), .error_continuation_ctl_out(cont),
    .seq_run_out(run), .seq_paused_out(paused), .pin_gpio_out(gpio),
    .pin_output_out(outm), .analog_channel_input_out(analog));

  adcm_host_model h (.clk_in(clk_in), .req_out(req), .ack_in(ack), .refused_in(refused),
    .rd_data_in(rdata), .rd_valid_in(rvalid));

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  // level inputs land on the next edge, seen settled one cycle on
  task automatic settle;
    repeat (2) @(negedge clk_in);
  endtask : settle

  task automatic t_reset;
    logic [7:0] addrs [4] = '{8'h03, 8'h04, 8'h05, 8'h07};
    foreach (addrs[i]) begin
      h.rd(addrs[i], d);
      chk("reset value", 8'h00, d);
    end
    h.rd(8'h20, d);
    chk("unmapped read", 8'h00, d);
    chk("reset analog", 8'hFF, analog);
    chk("reset run", 8'h01, {7'h0, run});
  endtask : t_reset

  task automatic t_avg;
    for (int c = 0; c < 8; c++) begin
      h.wr(8'h03, 8'hF8 | 8'(c), resp);
      chk("avg ack", 8'h02, {6'h0, resp});
      h.rd(8'h03, d);
      chk("avg readback", 8'(c), d);
      chk("avg code", 8'(c), {5'h0, avg});
      chk("avg samples", 8'h01 << c, samples);
    end
  endtask : t_avg

  task automatic t_opmode;
    h.wr(8'h04, 8'h3A, resp);
    h.rd(8'h04, d);
    chk("opmode readback", 8'h3A, d);
    chk("auto mode", 8'h01, {6'h0, mode});
    chk("lowpwr osc", 8'h01, {7'h0, osc});
    chk("divider", 8'h0A, {4'h0, cdiv});
    chk("divider used", 8'h01, {7'h0, cdiv_act});
    h.wr(8'h04, 8'h05, resp);
    h.rd(8'h04, d);
    chk("manual mode", 8'h00, {6'h0, mode});
    chk("fast osc", 8'h00, {7'h0, osc});
    chk("divider unused", 8'h00, {7'h0, cdiv_act});
  endtask : t_opmode

  task automatic t_pins;
    h.wr(8'h05, 8'h3C, resp);
    h.wr(8'h07, 8'h0F, resp);
    @(negedge clk_in);
    chk("gpio mask", 8'h3C, gpio);
    chk("output mask", 8'h0C, outm);
    chk("analog mask", 8'hC3, analog);
    force_an = 1'b1;
    settle();
    chk("forced gpio", 8'h00, gpio);
    chk("forced out", 8'h00, outm);
    chk("forced analog", 8'hFF, analog);
    force_an = 1'b0;
    settle();
    chk("unforced gpio", 8'h3C, gpio);
  endtask : t_pins

  // continuation clear: error only blocks writes
  task automatic t_crc_keep;
    crc_err = 1'b1;
    settle();
    chk("run kept", 8'h01, {7'h0, run});
    chk("pins kept", 8'h3C, gpio);
    h.wr(8'h05, 8'hFF, resp);
    chk("write refused", 8'h01, {6'h0, resp});
    h.wr(8'h01, 8'h00, resp);
    chk("exempt write", 8'h00, {6'h0, resp});
    h.rd(8'h05, d);
    chk("value kept", 8'h3C, d);
    crc_err = 1'b0;
    settle();
  endtask : t_crc_keep

  task automatic t_crc_pause;
    h.wr(8'h04, 8'h80, resp);
    @(negedge clk_in);
    chk("cont bit", 8'h01, {7'h0, cont});
    crc_err = 1'b1;
    settle();
    chk("paused", 8'h01, {7'h0, paused});
    chk("paused gpio", 8'h00, gpio);
    chk("paused analog", 8'hFF, analog);
    crc_err = 1'b0;
    settle();
    chk("resumed", 8'h01, {7'h0, run});
    chk("restored gpio", 8'h3C, gpio);
  endtask : t_crc_pause

  // the whole run needs well under a thousand cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      final_report();
    end
  end

  initial begin
    sys_rst_in = 1'b1;
    crc_err = 1'b0;
    force_an = 1'b0;
    repeat (6) @(negedge clk_in);
    sys_rst_in = 1'b0;
    t_reset();
    t_avg();
    t_opmode();
    t_pins();
    t_crc_keep();
    t_crc_pause();
    final_report();
  end
endmodule : tb
`default_nettype wire
